// >>> rtl/dwc_write_bus.sv
// Write clock generator, write multiplexer, CRC wiring and bus master
//
// Summary of operation
// - Divide 4 MHz into a 1 us two-phase timing, half high.
// - Divide two-phase into 4 us three-phase timing, each quarter active.
// - AND timings into strobe, data-bit and clock-bit write clocks.
// - Multiplexer passes data/CRC at data pulse, clock bit at clock pulse.
// - Selected drive with disk write: assert write gate, drive mux output.
// - Write line and write gate stay inactive during reads.
// - Generate and append two CRC characters per 129-byte data field.
// - CRC divides serial data by x^16 + x^12 + x^5 + 1.
// - Shift-out gate sends data to line and CRC; dropping it sends CRC.
// - Reads block data from the write line yet feed the CRC unit.
// - After field and recorded CRC, active-low all-zero shows a match.
// - Byte boundary latches all-zero into the CRC match flag.
// - CRC mode low shifts ones; CRC clocked by data shift strobe.
// - Memory request pulse sets request latch unless inhibit latch set.
// - Inhibit latch set and cleared by separate pulses.
// - Next bus clock after request sets transfer request, drives it low.
// - Request during an access sets overrun latch, drives overrun low.
// - Bus request follows transfer request by exactly one bus clock.
// - Bus free and priority in: next clock sets busy and selected.
// - Clock after busy enables the memory command drivers.
// - Memory write level picks exactly one memory command.
// - Hold latch keeps busy until memory command is removed.
// - Acknowledge clears transfer request, then bus is released.
// - Byte boundary flag marks a full byte shifted.
//
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ns
`default_nettype none
module dwc_write_bus #(
    parameter int REF_DIVIDE = dwc_pkg::REF_DIV
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic [dwc_pkg::ADDR_W-1:0] i_addr,
    input wire logic [dwc_pkg::DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [dwc_pkg::DATA_W-1:0] o_rdata,
    input wire logic i_read_data_strobe,
    input wire logic i_data_bit_serial_out,
    input wire logic i_clock_bit_serial_out,
    output logic o_data_shift_strobe,
    output logic o_clock_bit_shift_strobe,
    output logic o_byte_boundary,
    output logic o_crc_match_flag,
    output logic o_drive_write_gate_n,
    output logic o_drive_write_line_n,
    input wire dwc_pkg::dwc_bus_in_s i_bus,
    output logic o_transfer_request_n,
    output logic o_overrun_error_n,
    output logic o_breq_n,
    output logic o_busy_out_n,
    output logic o_busy_oe_n,
    output logic o_selected,
    output logic o_mrdc_n,
    output logic o_mwtc_n
);
    import dwc_pkg::*;

    logic [DATA_W-1:0] ctrl_reg;
    logic disk_write;
    logic drive_sel;
    logic shift_out_gate;
    logic crc_mode_level;
    logic memory_write_level;
    logic memory_request_pulse;
    logic inhibit_set_pulse;
    logic inhibit_clear_pulse;
    logic overrun_clear_pulse;
    logic [4:0] ref_cnt_reg;
    logic ref_tick;
    logic [1:0] tp_cnt_reg;
    logic two_phase;
    dwc_phase_e phase_reg;
    logic write_strobe;
    logic data_timing;
    logic clock_timing;
    logic data_shift_strobe;
    logic [2:0] bit_cnt_reg;
    logic crc_bit;
    logic all_zero_n;
    logic write_bit;
    dwc_bus_in_s bus_meta_reg;
    dwc_bus_in_s bus_sync_reg;
    logic inhibit_reg;
    logic req_reg;
    logic xfer_reg;
    logic breq_reg;
    logic busy_reg;
    logic cmd_rd_reg;
    logic cmd_wr_reg;
    logic hold_reg;
    logic overrun_reg;
    logic xack;

    // Control fields steer the write path and the bus direction
    assign disk_write = ctrl_reg[CTRL_DISK_WRITE];
    assign drive_sel = ctrl_reg[CTRL_DRIVE_SEL];
    assign shift_out_gate = ctrl_reg[CTRL_SHIFT_OUT];
    assign crc_mode_level = ctrl_reg[CTRL_CRC_MODE];
    assign memory_write_level = ctrl_reg[CTRL_MEM_WRITE];

    // Pulse register: a write makes one-cycle controller pulses
    assign memory_request_pulse = i_wr && i_addr == REG_PULSE && i_wdata[PUL_MEM_REQ];
    assign inhibit_set_pulse = i_wr && i_addr == REG_PULSE && i_wdata[PUL_INH_SET];
    assign inhibit_clear_pulse = i_wr && i_addr == REG_PULSE && i_wdata[PUL_INH_CLR];
    assign overrun_clear_pulse = i_wr && i_addr == REG_PULSE && i_wdata[PUL_OVR_CLR];

    // Control register write
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            ctrl_reg <= CTRL_RESET;
        end else if (i_wr && i_addr == REG_CTRL) begin
            ctrl_reg <= i_wdata;
        end
    end

    // Read data stand the cycle after the read strobe only
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_rdata <= '0;
        end else if (i_rd) begin
            case (i_addr)
                REG_CTRL: o_rdata <= ctrl_reg;
                REG_STATUS: begin
                    o_rdata <= '0;
                    o_rdata[ST_CRC_MATCH] <= o_crc_match_flag;
                    o_rdata[ST_OVERRUN] <= overrun_reg;
                    o_rdata[ST_TRANSFER_REQUEST_N] <= xfer_reg;
                    o_rdata[ST_BUSY] <= busy_reg;
                    o_rdata[ST_INHIBIT] <= inhibit_reg;
                end
                default: o_rdata <= '0;
            endcase
        end else begin
            o_rdata <= '0;
        end
    end

    // Reference tick at 4 MHz out of the system clock
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n || ref_tick) begin
            ref_cnt_reg <= '0;
        end else begin
            ref_cnt_reg <= ref_cnt_reg + 5'h1;
        end
    end
    assign ref_tick = (ref_cnt_reg == 5'(REF_DIVIDE - 1));

    // Two-phase timing: four reference ticks, two high
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            tp_cnt_reg <= '0;
        end else if (ref_tick) begin
            tp_cnt_reg <= tp_cnt_reg + 2'h1;
        end
    end
    assign two_phase = (tp_cnt_reg < 2'(TWO_PHASE_HIGH));

    // Three-phase timing steps once per microsecond
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            phase_reg <= PH_STROBE;
        end else if (ref_tick && tp_cnt_reg == 2'(TWO_PHASE_TICKS - 1)) begin
            case (phase_reg)
                PH_STROBE: phase_reg <= PH_DATA;
                PH_DATA: phase_reg <= PH_GAP;
                PH_GAP: phase_reg <= PH_CLOCK;
                PH_CLOCK: phase_reg <= PH_STROBE;
                default: phase_reg <= PH_STROBE;
            endcase
        end
    end

    // Write clocks are two-phase ANDed with one quarter
    assign data_timing = two_phase && phase_reg == PH_DATA;
    assign clock_timing = two_phase && phase_reg == PH_CLOCK;
    // Strobe is one cycle at the end of the clock quarter, just before the strobe quarter
    assign write_strobe = ref_tick && tp_cnt_reg == 2'(TWO_PHASE_TICKS - 1)
        && phase_reg == PH_CLOCK;

    // Write strobes only while writing, else the read strobe
    assign data_shift_strobe = disk_write ? write_strobe : i_read_data_strobe;

    // Shift strobes go out registered to the shift registers
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_data_shift_strobe <= 1'b0;
            o_clock_bit_shift_strobe <= 1'b0;
        end else begin
            o_data_shift_strobe <= data_shift_strobe;
            o_clock_bit_shift_strobe <= disk_write && write_strobe;
        end
    end

    // Bit counter marks each full byte
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            bit_cnt_reg <= '0;
            o_byte_boundary <= 1'b0;
        end else begin
            o_byte_boundary <= data_shift_strobe && bit_cnt_reg == 3'(BYTE_BITS - 1);
            if (data_shift_strobe) begin
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
            end
        end
    end

    // CRC sees data both when writing and when reading
    dwc_crc_unit u_crc (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_strobe(data_shift_strobe),
        .i_crc_mode(crc_mode_level),
        .i_divide(shift_out_gate || !disk_write),
        .i_bit(i_data_bit_serial_out),
        .o_crc_bit(crc_bit),
        .o_all_zero_n(all_zero_n)
    );

    // Latch match at the byte boundary
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_crc_match_flag <= 1'b0;
        end else if (o_byte_boundary) begin
            o_crc_match_flag <= !all_zero_n;
        end
    end

    // Data until the gate drops, then the appended CRC
    assign write_bit = shift_out_gate ? i_data_bit_serial_out : crc_bit;

    // Drive side: gate and line only while writing
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_drive_write_gate_n <= 1'b1;
            o_drive_write_line_n <= 1'b1;
        end else begin
            o_drive_write_gate_n <= !(drive_sel && disk_write);
            o_drive_write_line_n <= !(drive_sel && disk_write
                && ((data_timing && write_bit)
                || (clock_timing && i_clock_bit_serial_out)));
        end
    end

    // Bus pins pass two flops before use
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            bus_meta_reg <= '1;
            bus_sync_reg <= '1;
        end else begin
            bus_meta_reg <= i_bus;
            bus_sync_reg <= bus_meta_reg;
        end
    end
    assign xack = !bus_sync_reg.xack_n;

    // Inhibit latch; clear wins if both pulse together
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            inhibit_reg <= 1'b0;
        end else if (inhibit_clear_pulse) begin
            inhibit_reg <= 1'b0;
        end else if (inhibit_set_pulse) begin
            inhibit_reg <= 1'b1;
        end
    end

    // Request chain, cleared by acknowledge
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            req_reg <= 1'b0;
            xfer_reg <= 1'b0;
            breq_reg <= 1'b0;
        end else begin
            if (xack) begin
                req_reg <= 1'b0;
            end else if (memory_request_pulse && !inhibit_reg) begin
                req_reg <= 1'b1;
            end
            xfer_reg <= req_reg && !xack;
            breq_reg <= xfer_reg && !xack;
        end
    end

    // Overrun: set wins over a software clear
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            overrun_reg <= 1'b0;
        end else if (memory_request_pulse && (req_reg || xfer_reg)) begin
            overrun_reg <= 1'b1;
        end else if (overrun_clear_pulse) begin
            overrun_reg <= 1'b0;
        end
    end

    // Busy, commands and hold; hold keeps busy up
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            busy_reg <= 1'b0;
            cmd_rd_reg <= 1'b0;
            cmd_wr_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else begin
            if (!busy_reg) begin
                busy_reg <= breq_reg && bus_sync_reg.busy_n && !bus_sync_reg.bprn_n;
            end else if (!xfer_reg && !hold_reg) begin
                busy_reg <= 1'b0;
            end
            cmd_rd_reg <= busy_reg && xfer_reg && !memory_write_level;
            cmd_wr_reg <= busy_reg && xfer_reg && memory_write_level;
            hold_reg <= (cmd_rd_reg || cmd_wr_reg) && busy_reg;
        end
    end

    // Bus pins straight from flops, mirroring the latches
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_transfer_request_n <= 1'b1;
            o_overrun_error_n <= 1'b1;
            o_breq_n <= 1'b1;
            o_busy_out_n <= 1'b0;
            o_busy_oe_n <= 1'b1;
            o_selected <= 1'b0;
            o_mrdc_n <= 1'b1;
            o_mwtc_n <= 1'b1;
        end else begin
            o_transfer_request_n <= !(req_reg && !xack);
            o_overrun_error_n <= !(overrun_reg
                || (memory_request_pulse && (req_reg || xfer_reg)));
            o_breq_n <= !(xfer_reg && !xack);
            o_busy_out_n <= 1'b0; // Open drain: only ever pulls low
            o_busy_oe_n <= !busy_reg;
            o_selected <= busy_reg;
            o_mrdc_n <= !cmd_rd_reg;
            o_mwtc_n <= !cmd_wr_reg;
        end
    end

    // Checks on the timing and bus sequence
    chk_two_phase_half: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (ref_tick && tp_cnt_reg == 2'h3) |=> two_phase)
        else $error("two-phase not high at period start");
    chk_write_strobe_cycle: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        write_strobe |=> phase_reg == PH_STROBE)
        else $error("strobe not at three-phase start");
    chk_gate_in_read: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !disk_write |=> o_drive_write_gate_n && o_drive_write_line_n)
        else $error("write pins active during read");
    chk_inhibit_blocks: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (memory_request_pulse && inhibit_reg && !req_reg) |=> !req_reg)
        else $error("request taken while inhibited");
    chk_xfer_follows: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (req_reg && !xack) |=> xfer_reg)
        else $error("transfer request late");
    chk_breq_lag: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $fell(o_transfer_request_n) |=> $fell(o_breq_n))
        else $error("bus request not one clock after transfer");
    chk_overrun_set: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (memory_request_pulse && xfer_reg) |=> !o_overrun_error_n && overrun_reg)
        else $error("overrun missed");
    chk_one_command: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        !(cmd_rd_reg && cmd_wr_reg))
        else $error("both memory commands active");
    chk_cmd_after_busy: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(busy_reg) && xfer_reg |=> (cmd_rd_reg || cmd_wr_reg))
        else $error("command not one clock after busy");
    chk_hold_keeps_busy: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        hold_reg |=> busy_reg)
        else $error("busy dropped under hold");
    chk_match_latch: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_byte_boundary |=> o_crc_match_flag == !$past(all_zero_n))
        else $error("match flag not latched at boundary");

    cov_bus_grant: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(busy_reg));
    cov_release: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $fell(busy_reg));
    cov_overrun: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(overrun_reg));
    cov_crc_match: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        $rose(o_crc_match_flag));
endmodule // dwc_write_bus
`default_nettype wire

// >>> rtl/dwc_pkg.sv
// Shared constants and types of the diskette write, CRC and bus master block
package dwc_pkg;
    // Clock rates and timing figures
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int REF_CLK_HZ = 4_000_000;
    localparam int REF_DIV = SYS_CLK_HZ / REF_CLK_HZ;
    localparam int TWO_PHASE_NS = 1000;
    localparam int REF_PERIOD_NS = 250;
    localparam int TWO_PHASE_TICKS = TWO_PHASE_NS / REF_PERIOD_NS;
    localparam int TWO_PHASE_HIGH = TWO_PHASE_TICKS / 2;
    localparam int BYTE_BITS = 8;
    localparam int CRC_W = 16;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_PRESET = 16'hffff;

    // Register indices on the plain register port
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam logic [1:0] REG_CTRL = 2'h0;
    localparam logic [1:0] REG_PULSE = 2'h1;
    localparam logic [1:0] REG_STATUS = 2'h2;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Control register fields
    localparam int CTRL_DISK_WRITE = 0;
    localparam int CTRL_DRIVE_SEL = 1;
    localparam int CTRL_SHIFT_OUT = 2;
    localparam int CTRL_CRC_MODE = 3;
    localparam int CTRL_MEM_WRITE = 4;

    // Pulse register fields
    localparam int PUL_MEM_REQ = 0;
    localparam int PUL_INH_SET = 1;
    localparam int PUL_INH_CLR = 2;
    localparam int PUL_OVR_CLR = 3;

    // Status register fields
    localparam int ST_CRC_MATCH = 0;
    localparam int ST_OVERRUN = 1;
    localparam int ST_TRANSFER_REQUEST_N = 2;
    localparam int ST_BUSY = 3;
    localparam int ST_INHIBIT = 4;

    // Quarter of the four microsecond write cycle, one-hot
    typedef enum logic [3:0] {
        PH_STROBE = 4'h1,
        PH_DATA = 4'h2,
        PH_GAP = 4'h4,
        PH_CLOCK = 4'h8
    } dwc_phase_e;

    // Bus pins sampled from the system bus
    typedef struct packed {
        logic busy_n;
        logic bprn_n;
        logic xack_n;
    } dwc_bus_in_s;
endpackage

// >>> rtl/dwc_crc_unit.sv
// Serial CRC generator and checker clocked by the data shift strobe
`timescale 1ns/1ns
`default_nettype none
module dwc_crc_unit #(
    parameter int W = dwc_pkg::CRC_W,
    parameter logic [15:0] POLY = dwc_pkg::CRC_POLY
) (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_strobe,
    input wire logic i_crc_mode,
    input wire logic i_divide,
    input wire logic i_bit,
    output logic o_crc_bit,
    output logic o_all_zero_n
);
    import dwc_pkg::*;

    logic [W-1:0] crc_reg;
    logic [W-1:0] crc_next;
    logic fb;

    // Divide while dividing; otherwise shift the remainder out
    always_comb begin
        fb = crc_reg[W-1] ^ i_bit;
        if (!i_crc_mode) begin
            crc_next = CRC_PRESET; // Ones flow in
        end else if (i_divide) begin
            crc_next = {crc_reg[W-2:0], 1'b0} ^ (fb ? POLY : '0);
        end else begin
            crc_next = {crc_reg[W-2:0], 1'b0};
        end
    end

    // Remainder advances only on a shift strobe
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            crc_reg <= CRC_PRESET;
        end else if (i_strobe) begin
            crc_reg <= crc_next;
        end
    end

    assign o_crc_bit = crc_reg[W-1];
    // Zero remainder means recorded CRC matched
    assign o_all_zero_n = (crc_reg != '0);

    chk_crc_preset: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        (i_strobe && !i_crc_mode) |=> (crc_reg == CRC_PRESET))
        else $error("CRC not preset while mode low");
endmodule // dwc_crc_unit
`default_nettype wire

// >>> tb/dwc_bus_partner.sv
// Bus arbiter and memory model facing the bus master side
`timescale 1ns/1ns
`default_nettype none
module dwc_bus_partner (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_slow,
    input wire logic i_breq_n,
    input wire logic i_busy_out_n,
    input wire logic i_busy_oe_n,
    input wire logic i_mrdc_n,
    input wire logic i_mwtc_n,
    output var dwc_pkg::dwc_bus_in_s o_bus
);
    import dwc_pkg::*;
    logic [4:0] gnt_cnt;
    logic [4:0] ack_cnt;
    logic [4:0] lim;
    logic bprn_n;
    logic xack_n;
    // Busy line has a pull-up, so it is high unless someone drives it
    assign o_bus = {i_busy_oe_n | i_busy_out_n, bprn_n, xack_n};
    assign lim = i_slow ? 5'h0c : 5'h01;
    // Priority granted some cycles after the request, dropped with it
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n || i_breq_n) begin
            gnt_cnt <= 5'h00;
            bprn_n <= 1'b1;
        end else begin
            gnt_cnt <= gnt_cnt + 5'h01;
            bprn_n <= (gnt_cnt < lim);
        end
    end
    // Memory acknowledges either command and holds until it is removed
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n || (i_mrdc_n && i_mwtc_n)) begin
            ack_cnt <= 5'h00;
            xack_n <= 1'b1;
        end else begin
            ack_cnt <= ack_cnt + 5'h01;
            xack_n <= (ack_cnt < lim);
        end
    end
endmodule // dwc_bus_partner
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the write, CRC and bus master block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import dwc_pkg::*;
    logic clk, rst_n, wr, rd, rstb, dbit, cbit, slow;
    logic dss, css, bb, match, gate_n, line_n;
    logic tr_n, ovr_n, breq_n, bo_n, boe_n, sel, mrdc_n, mwtc_n;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, r;
    logic [15:0] good;
    dwc_bus_in_s bus;
    int errors, check_count, cyc, nbb, nds, l, g, c0;

    // Device with the default reference divider
    dwc_write_bus u_dwc_write_bus (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_read_data_strobe(rstb),
        .i_data_bit_serial_out(dbit), .i_clock_bit_serial_out(cbit),
        .o_data_shift_strobe(dss), .o_clock_bit_shift_strobe(css),
        .o_byte_boundary(bb), .o_crc_match_flag(match), .o_drive_write_gate_n(gate_n),
        .o_drive_write_line_n(line_n), .i_bus(bus), .o_transfer_request_n(tr_n),
        .o_overrun_error_n(ovr_n), .o_breq_n(breq_n), .o_busy_out_n(bo_n),
        .o_busy_oe_n(boe_n), .o_selected(sel), .o_mrdc_n(mrdc_n), .o_mwtc_n(mwtc_n));
    dwc_bus_partner u_dwc_bus_partner (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_slow(slow), .i_breq_n(breq_n),
        .i_busy_out_n(bo_n), .i_busy_oe_n(boe_n), .i_mrdc_n(mrdc_n),
        .i_mwtc_n(mwtc_n), .o_bus(bus));

    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Cycle and pulse counters; the cycle ceiling cuts a hang short
    always @(posedge clk) begin
        cyc++;
        if (bb === 1'b1) nbb++;
        if (dss === 1'b1) nds++;
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] v);
        check_count++;
        if (v !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, v);
        end
    endtask
    task automatic results;
        $display("errors %0d check_count %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Settle past the edge so sampled outputs are stable
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic rst_seq;
        @(posedge clk) rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    task automatic wreg(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk) wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rreg(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk) rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic count_low(input int n);
        l = 0;
        g = 0;
        repeat (n) begin
            tick(1);
            l += (line_n === 1'b0);
            g += (gate_n === 1'b0);
        end
    endtask
    // One read bit, data held steady around its strobe
    task automatic rbit(input logic b);
        @(posedge clk) dbit <= b;
        @(posedge clk) rstb <= 1'b1;
        @(posedge clk) rstb <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    function automatic logic [15:0] crc_of(input logic [15:0] d);
        logic [15:0] c;
        c = CRC_PRESET;
        for (int i = 15; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0);
        return c;
    endfunction
    // Preset with mode low, two data bytes, then the recorded check bits
    task automatic crc_run(input logic [15:0] sent, input logic e);
        rst_seq();
        wreg(REG_CTRL, 8'h02);
        nbb = 0;
        nds = 0;
        repeat (8) rbit(1'b1);
        wreg(REG_CTRL, 8'h0a);
        for (int i = 15; i >= 0; i--) rbit(good[i] ^ 1'b0 ? 1'b1 : 1'b0);
        for (int i = 15; i >= 0; i--) rbit(sent[i]);
        tick(4);
        chk("byte_bound", 16'd5, nbb[15:0]);
        chk("shift_strobes", 16'd40, nds[15:0]);
        chk("crc_match", e, match);
        chk("idle_write", 2'b11, {gate_n, line_n});
    endtask
    task automatic bus_xfer(input logic mw);
        wreg(REG_CTRL, {3'h0, mw, 4'h0});
        wreg(REG_PULSE, 8'h01);
        for (int i = 0; i < 10 && tr_n !== 1'b0; i++) tick(1);
        chk("breq_lead", 1'b1, breq_n);
        tick(1);
        chk("breq", 1'b0, breq_n);
        for (int i = 0; i < 40 && sel !== 1'b1; i++) tick(1);
        chk("busy_oe", 1'b0, boe_n);
        for (int i = 0; i < 10 && (mrdc_n & mwtc_n) !== 1'b0; i++) tick(1);
        chk("cmd", {mw, !mw}, {mrdc_n, mwtc_n});
        chk("busy_held", 1'b0, boe_n);
        for (int i = 0; i < 60 && boe_n !== 1'b1; i++) tick(1);
        chk("release", 6'h3e, {tr_n, breq_n, mrdc_n, mwtc_n, ovr_n, sel});
    endtask

    // Main sequence
    initial begin
        {rst_n, wr, rd, rstb, dbit, cbit, slow, addr, wdata} = '0;
        rst_seq();
        tick(1);
        chk("rst_hi", 8'hff, {tr_n, breq_n, ovr_n, mrdc_n, mwtc_n, boe_n, gate_n, line_n});
        chk("rst_lo", 3'h0, {bo_n, sel, match});
        rreg(REG_CTRL, r);
        chk("ctrl_rst", CTRL_RESET, r);
        rreg(2'h3, r);
        chk("unmapped", 8'h00, r);
        wreg(REG_CTRL, 8'h1f);
        rreg(REG_CTRL, r);
        chk("ctrl_rw", 8'h1f, r);
        {dbit, cbit} <= 2'b11;
        wreg(REG_CTRL, 8'h05);
        count_low(800);
        chk("unselected", 16'd0, 16'(l + g));
        wreg(REG_CTRL, 8'h07);
        for (int k = 0; k < 4; k++) begin
            {cbit, dbit} <= k[1:0];
            tick(400);
            count_low(400);
            chk("line_low", 16'((k % 2 + k / 2) * 50), l[15:0]);
            chk("gate_low", 16'd400, g[15:0]);
        end
        // Gate dropped with mode low: preset ones reach the line in data quarters
        {cbit, dbit} <= 2'b00;
        wreg(REG_CTRL, 8'h03);
        count_low(400);
        chk("crc_out", 16'd50, l[15:0]);
        for (int i = 0; i < 500 && dss !== 1'b1; i++) tick(1);
        chk("clk_strobe", 1'b1, css);
        c0 = cyc;
        tick(1);
        for (int i = 0; i < 500 && dss !== 1'b1; i++) tick(1);
        chk("strobe_period", 16'd400, 16'(cyc - c0));
        wreg(REG_CTRL, 8'h02);
        count_low(400);
        chk("read_idle", 16'd0, 16'(l + g));
        good = 16'ha53c;
        crc_run(crc_of(good) ^ 16'h0001, 1'b0);
        crc_run(crc_of(good), 1'b1);
        bus_xfer(1'b0);
        slow <= 1'b1;
        bus_xfer(1'b1);
        wreg(REG_PULSE, 8'h01);
        wreg(REG_PULSE, 8'h01);
        tick(2);
        chk("overrun", 1'b0, ovr_n);
        rreg(REG_STATUS, r);
        chk("st_ovr", 1'b1, r[ST_OVERRUN]);
        // Let the pending access win the bus and finish before inhibiting
        for (int i = 0; i < 40 && sel !== 1'b1; i++) tick(1);
        for (int i = 0; i < 80 && boe_n !== 1'b1; i++) tick(1);
        wreg(REG_PULSE, 8'h0a);
        rreg(REG_STATUS, r);
        chk("ovr_inh", 2'b01, {r[ST_OVERRUN], r[ST_INHIBIT]});
        wreg(REG_PULSE, 8'h01);
        tick(10);
        chk("inhibited", 1'b1, tr_n);
        wreg(REG_PULSE, 8'h04);
        rreg(REG_STATUS, r);
        chk("inh_clr", 1'b0, r[ST_INHIBIT]);
        bus_xfer(1'b0);
        results();
    end
endmodule // tb_top
`default_nettype wire
